// ### hw/cbi_pkg.sv
package cbi_pkg;

  // ----------------------------------------------------------------------
  // Reset values, fixed addresses and bus geometry.
  // ----------------------------------------------------------------------
  localparam logic [15:0] CBI_PC_RESET = 16'h0000;
  localparam logic [7:0] CBI_VEC_PAGE_RESET = 8'h00;
  localparam logic [7:0] CBI_REFRESH_RESET = 8'h00;
  localparam logic [1:0] CBI_IMODE_RESET = 2'h0;
  localparam logic [15:0] CBI_NMI_VECTOR = 16'h0066;
  localparam logic [15:0] CBI_SP_RESET = 16'hFFFF;
  localparam int CBI_REFRESH_BITS = 7;

  // Register port offsets.
  localparam logic [3:0] CBI_REG_CTRL = 4'h0;
  localparam logic [3:0] CBI_REG_STATUS = 4'h1;
  localparam logic [3:0] CBI_REG_VEC_PAGE = 4'h2;
  localparam logic [3:0] CBI_REG_REFRESH = 4'h3;
  localparam logic [3:0] CBI_REG_INDEX1 = 4'h4;
  localparam logic [3:0] CBI_REG_INDEX2 = 4'h5;
  localparam logic [3:0] CBI_REG_PC = 4'h6;
  localparam logic [3:0] CBI_REG_CMD = 4'h7;
  localparam logic [3:0] CBI_REG_DATA = 4'h8;
  localparam logic [3:0] CBI_REG_ALU = 4'h9;

  // Command register field positions.
  localparam int CBI_CMD_KIND_LSB = 0;
  localparam int CBI_CMD_DISP_LSB = 8;
  localparam int CBI_CMD_ADDR_LSB = 16;

  // Control register field positions.
  localparam int CBI_CTRL_IEN_BIT = 0;
  localparam int CBI_CTRL_IMODE_LSB = 1;
  localparam int CBI_CTRL_IDX_BIT = 3;

  // ----------------------------------------------------------------------
  // Enumerations.
  // ----------------------------------------------------------------------
  typedef enum logic [3:0]
  {
    CBI_CMD_FETCH, CBI_CMD_FETCH2, CBI_CMD_MEM_RD, CBI_CMD_MEM_WR, CBI_CMD_IO_RD,
    CBI_CMD_IO_WR, CBI_CMD_IDX_RD, CBI_CMD_IDX_WR, CBI_CMD_HALT, CBI_CMD_NONE
  } cbi_cmd_t;

  typedef enum logic [3:0]
  {
    CBI_ALU_ADD, CBI_ALU_SUB, CBI_ALU_AND, CBI_ALU_OR, CBI_ALU_XOR, CBI_ALU_CMP,
    CBI_ALU_SHL, CBI_ALU_SHR, CBI_ALU_ROL, CBI_ALU_ROR, CBI_ALU_INC, CBI_ALU_DEC,
    CBI_ALU_SET, CBI_ALU_RES, CBI_ALU_TST
  } cbi_alu_op_t;

  // ----------------------------------------------------------------------
  // Bus pin bundles.
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic opcode_fetch_cycle_n;
    logic memory_request_n;
    logic port_request_n;
    logic read_n;
    logic write_n;
    logic refresh_strobe_n;
  } cbi_ctrl_t;

  localparam cbi_ctrl_t CBI_CTRL_IDLE = 6'h3F;

endpackage

// ### hw/cbi_core.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - Indexed address is base plus signed displacement.
// - Vector address is page high, peripheral low.
// - Fetch increments refresh low seven bits only.
// - Refresh drives counter low, page high.
// - Sixteen-bit memory address, eight-bit port address.
// - Opcode-fetch flag on every opcode byte.
// - Acknowledge is port request with fetch flag.
// - Memory request only with valid address.
// - Write strobe only with valid data.
// - Refresh strobe with refresh address, memory request.
// - Halt output, idle refresh until interrupt.
// - Wait states continue while wait asserted.
// - Maskable taken at end, enabled, no hold.
// - Acknowledge next cycle; only mode 2 forms a vector address.
// - Falling edge NMI pushes counter, restarts fixed.
// - Hold beats NMI; waits delay recognition.
// - Reset clears counter, enable, page, refresh, mode.
// - Reset floats buses, controls inactive.
// - Hold request floats buses after cycle.
// - Grant asserted once buses float.
// - Arithmetic unit offers the listed functions.
// - Wait sampled in T2 and each wait state.
// - Hold request sampled in last cycle period.
module cbi_core
  import cbi_pkg::*;
(
  input wire logic sys_clk, // Single system clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic [3:0] reg_addr, // Register port address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [31:0] reg_rdata, // Register read data, one cycle later.
  output logic [15:0] addr_o, // Address bus value.
  output logic addr_oe, // Address bus drive enable.
  input wire logic [7:0] data_i, // Data bus input.
  output logic [7:0] data_o, // Data bus output.
  output logic data_oe, // Data bus drive enable.
  output cbi_ctrl_t ctrl_o, // Tri-state control strobes.
  output logic ctrl_oe, // Control strobe drive enable.
  output logic halt_n, // Halt indication.
  output logic bus_hold_grant_n, // Bus grant.
  input wire logic wait_n, // Wait request pin.
  input wire logic int_n, // Maskable interrupt pin.
  input wire logic nmi_n, // Non-maskable interrupt pin.
  input wire logic bus_hold_request_n // Bus request pin.
);

  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3, ST_T4, ST_HOLD} cbi_state_t;

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic nmi_prev_r;
  logic wait_act, int_act, nmi_lvl, hold_act;

  // Two flops on every pin input.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      pin_s1_r <= 4'hF;
      pin_s2_r <= 4'hF;
      nmi_prev_r <= 1'b1;
    end
    else
    begin
      pin_s1_r <= {bus_hold_request_n, nmi_n, int_n, wait_n};
      pin_s2_r <= pin_s1_r;
      nmi_prev_r <= pin_s2_r[2];
    end
  end

  assign wait_act = !pin_s2_r[0];
  assign int_act = !pin_s2_r[1];
  assign nmi_lvl = pin_s2_r[2];
  assign hold_act = !pin_s2_r[3];

  // ----------------------------------------------------------------------
  // Architectural registers.
  // ----------------------------------------------------------------------
  cbi_state_t state_r;
  cbi_cmd_t kind_r;
  logic [15:0] pc_r, sp_r, index_base_first_r, index_base_second_r, cyc_addr_r;
  logic [7:0] vec_page_r, refresh_r, wdata_r, rdata_r, disp_r;
  logic [1:0] imode_r;
  logic irq_enable_flop_r, idx_sel_r, halted_r, nmi_pend_r, ack_pend_r, is_ack_r, busy_r;
  logic [2:0] push_cnt_r;
  logic cmd_go;
  logic cyc_end;
  logic [15:0] idx_addr;

  // Sign-extended displacement added to the chosen base.
  assign idx_addr = (idx_sel_r ? index_base_second_r : index_base_first_r) + {{8{disp_r[7]}}, disp_r};

  assign cmd_go = reg_wr && (reg_addr == CBI_REG_CMD);
  // A cycle ends in T3 of ordinary cycles or T4 of fetches.
  assign cyc_end = (state_r == ST_T4) ||
                   (state_r == ST_T3 && kind_r != CBI_CMD_FETCH && kind_r != CBI_CMD_FETCH2 && !is_ack_r);

  // Edge detection on the resynchronised NMI; a pending request survives a hold.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      nmi_pend_r <= 1'b0;
    else if (nmi_prev_r && !nmi_lvl)
      nmi_pend_r <= 1'b1;
    else if (state_r == ST_IDLE && !hold_act && !busy_r)
      nmi_pend_r <= 1'b0;
  end

  // Machine cycle sequencer.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
          if (hold_act)
            state_r <= ST_HOLD;
          else if (cmd_go || busy_r || halted_r || ack_pend_r || nmi_pend_r)
            state_r <= ST_T1;
        ST_T1:
          state_r <= ST_T2;
        ST_T2:
          state_r <= wait_act ? ST_TW : ST_T3;
        ST_TW:
          state_r <= wait_act ? ST_TW : ST_T3;
        ST_T3:
          if (cyc_end)
            state_r <= hold_act ? ST_HOLD : ST_IDLE;
          else
            state_r <= ST_T4;
        ST_T4:
          state_r <= hold_act ? ST_HOLD : ST_IDLE;
        ST_HOLD:
          if (!hold_act)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Cycle kind, address and interrupt response.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      kind_r <= CBI_CMD_NONE;
      cyc_addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      disp_r <= 8'h00;
      halted_r <= 1'b0;
      ack_pend_r <= 1'b0;
      is_ack_r <= 1'b0;
      busy_r <= 1'b0;
      push_cnt_r <= 3'h0;
      pc_r <= CBI_PC_RESET;
      sp_r <= CBI_SP_RESET;
    end
    else if (state_r == ST_IDLE && !hold_act)
    begin
      is_ack_r <= 1'b0;
      if (nmi_pend_r && !busy_r)
      begin
        // Push the counter high then low, then restart.
        halted_r <= 1'b0;
        busy_r <= 1'b1;
        push_cnt_r <= 3'h2;
        kind_r <= CBI_CMD_MEM_WR;
        cyc_addr_r <= sp_r - 16'h0001;
        wdata_r <= pc_r[15:8];
        sp_r <= sp_r - 16'h0001;
      end
      else if (busy_r && push_cnt_r == 3'h2)
      begin
        push_cnt_r <= 3'h1;
        kind_r <= CBI_CMD_MEM_WR;
        cyc_addr_r <= sp_r - 16'h0001;
        wdata_r <= pc_r[7:0];
        sp_r <= sp_r - 16'h0001;
      end
      else if (busy_r)
      begin
        busy_r <= 1'b0;
        push_cnt_r <= 3'h0;
        pc_r <= CBI_NMI_VECTOR;
        kind_r <= CBI_CMD_FETCH;
        cyc_addr_r <= CBI_NMI_VECTOR;
      end
      else if (ack_pend_r)
      begin
        // Acknowledge runs as the next fetch cycle.
        ack_pend_r <= 1'b0;
        halted_r <= 1'b0;
        is_ack_r <= 1'b1;
        kind_r <= CBI_CMD_FETCH;
        cyc_addr_r <= pc_r;
      end
      else if (cmd_go)
      begin
        kind_r <= cbi_cmd_t'(reg_wdata[CBI_CMD_KIND_LSB +: 4]);
        disp_r <= reg_wdata[CBI_CMD_DISP_LSB +: 8];
        wdata_r <= reg_wdata[CBI_CMD_DISP_LSB +: 8];
        cyc_addr_r <= reg_wdata[CBI_CMD_ADDR_LSB +: 16];
        if (reg_wdata[CBI_CMD_KIND_LSB +: 4] == 4'(CBI_CMD_HALT))
          halted_r <= 1'b1;
      end
      else if (halted_r)
      begin
        kind_r <= CBI_CMD_FETCH;
        cyc_addr_r <= pc_r;
      end
    end
    else if (state_r == ST_T1 && (kind_r == CBI_CMD_IDX_RD || kind_r == CBI_CMD_IDX_WR))
      cyc_addr_r <= idx_addr;
    else if (cyc_end)
    begin
      if ((kind_r == CBI_CMD_FETCH || kind_r == CBI_CMD_FETCH2) && !halted_r && !is_ack_r)
        pc_r <= pc_r + 16'h0001;
      // Maskable taken only at a machine cycle end, enabled, without hold.
      if (int_act && irq_enable_flop_r && !hold_act && !nmi_pend_r && !busy_r)
        ack_pend_r <= 1'b1;
      if (is_ack_r && imode_r == 2'h2)
        cyc_addr_r <= {vec_page_r, rdata_r};
    end
  end

  // Read data capture in T3.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rdata_r <= 8'h00;
    else if (state_r == ST_T3 && kind_r != CBI_CMD_MEM_WR && kind_r != CBI_CMD_IO_WR && kind_r != CBI_CMD_IDX_WR)
      rdata_r <= data_i;
  end

  // Software-visible page, index and mode registers; refresh counting.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      vec_page_r <= CBI_VEC_PAGE_RESET;
      refresh_r <= CBI_REFRESH_RESET;
      imode_r <= CBI_IMODE_RESET;
      irq_enable_flop_r <= 1'b0;
      idx_sel_r <= 1'b0;
      index_base_first_r <= 16'h0000;
      index_base_second_r <= 16'h0000;
    end
    else
    begin
      if (reg_wr && reg_addr == CBI_REG_CTRL)
      begin
        irq_enable_flop_r <= reg_wdata[CBI_CTRL_IEN_BIT];
        imode_r <= reg_wdata[CBI_CTRL_IMODE_LSB +: 2];
        idx_sel_r <= reg_wdata[CBI_CTRL_IDX_BIT];
      end
      else if (state_r == ST_IDLE && ack_pend_r && !hold_act && !nmi_pend_r && !busy_r)
        irq_enable_flop_r <= 1'b0;
      if (reg_wr && reg_addr == CBI_REG_VEC_PAGE)
        vec_page_r <= reg_wdata[7:0];
      if (reg_wr && reg_addr == CBI_REG_INDEX1)
        index_base_first_r <= reg_wdata[15:0];
      if (reg_wr && reg_addr == CBI_REG_INDEX2)
        index_base_second_r <= reg_wdata[15:0];
      if (reg_wr && reg_addr == CBI_REG_REFRESH)
        refresh_r <= reg_wdata[7:0];
      else if (state_r == ST_T4)
        refresh_r <= {refresh_r[7], refresh_r[6:0] + 7'h01};
    end
  end

  // ----------------------------------------------------------------------
  // Arithmetic unit.
  // ----------------------------------------------------------------------
  function automatic logic [8:0] alu_calc(input cbi_alu_op_t op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] r;
    r = 9'h000;
    case (op)
      CBI_ALU_ADD: r = {1'b0, a} + {1'b0, b};
      CBI_ALU_SUB, CBI_ALU_CMP: r = {1'b0, a} - {1'b0, b};
      CBI_ALU_AND: r = {1'b0, a & b};
      CBI_ALU_OR: r = {1'b0, a | b};
      CBI_ALU_XOR: r = {1'b0, a ^ b};
      CBI_ALU_SHL: r = {a, 1'b0};
      CBI_ALU_SHR: r = {a[0], 1'b0, a[7:1]};
      CBI_ALU_ROL: r = {a[7], a[6:0], a[7]};
      CBI_ALU_ROR: r = {a[0], a[0], a[7:1]};
      CBI_ALU_INC: r = {1'b0, a} + 9'h001;
      CBI_ALU_DEC: r = {1'b0, a} - 9'h001;
      CBI_ALU_SET: r = {1'b0, a | (8'h01 << b[2:0])};
      CBI_ALU_RES: r = {1'b0, a & ~(8'h01 << b[2:0])};
      CBI_ALU_TST: r = {8'h00, a[b[2:0]]};
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  logic [8:0] alu_res_r;

  // Operands and operation come from one register write.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      alu_res_r <= 9'h000;
    else if (reg_wr && reg_addr == CBI_REG_ALU)
      alu_res_r <= alu_calc(cbi_alu_op_t'(reg_wdata[19:16]), reg_wdata[7:0], reg_wdata[15:8]);
  end

  // ----------------------------------------------------------------------
  // Register read port.
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        CBI_REG_CTRL: reg_rdata <= {28'h000_0000, idx_sel_r, imode_r, irq_enable_flop_r};
        CBI_REG_STATUS: reg_rdata <= {24'h00_0000, 1'b0, state_r, halted_r, nmi_pend_r, ack_pend_r, 1'b0};
        CBI_REG_VEC_PAGE: reg_rdata <= {24'h00_0000, vec_page_r};
        CBI_REG_REFRESH: reg_rdata <= {24'h00_0000, refresh_r};
        CBI_REG_INDEX1: reg_rdata <= {16'h0000, index_base_first_r};
        CBI_REG_INDEX2: reg_rdata <= {16'h0000, index_base_second_r};
        CBI_REG_PC: reg_rdata <= {sp_r, pc_r};
        CBI_REG_DATA: reg_rdata <= {24'h00_0000, rdata_r};
        CBI_REG_ALU: reg_rdata <= {23'h00_0000, alu_res_r};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs, registered.
  // ----------------------------------------------------------------------
  logic is_fetch, is_io, is_wr, in_mid, in_ref;
  assign is_fetch = (kind_r == CBI_CMD_FETCH || kind_r == CBI_CMD_FETCH2);
  assign is_io = (kind_r == CBI_CMD_IO_RD || kind_r == CBI_CMD_IO_WR);
  assign is_wr = (kind_r == CBI_CMD_MEM_WR || kind_r == CBI_CMD_IO_WR || kind_r == CBI_CMD_IDX_WR);

  always_comb
  begin
    in_mid = 1'b0;
    in_ref = 1'b0;
    case (state_r)
      ST_T1, ST_T2, ST_TW: in_mid = 1'b1;
      ST_T3:
      begin
        in_mid = !is_fetch;
        in_ref = is_fetch;
      end
      ST_T4: in_ref = is_fetch;
      default: in_mid = 1'b0;
    endcase
  end

  // Bus drive; floated under reset and hold.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      addr_o <= 16'h0000;
      addr_oe <= 1'b0;
      data_o <= 8'h00;
      data_oe <= 1'b0;
      ctrl_o <= CBI_CTRL_IDLE;
      ctrl_oe <= 1'b0;
      halt_n <= 1'b1;
      bus_hold_grant_n <= 1'b1;
    end
    else
    begin
      addr_oe <= (state_r != ST_HOLD);
      ctrl_oe <= (state_r != ST_HOLD);
      bus_hold_grant_n <= (state_r != ST_HOLD);
      halt_n <= !halted_r;
      ctrl_o <= CBI_CTRL_IDLE;
      data_oe <= 1'b0;
      data_o <= wdata_r;
      if (in_ref)
      begin
        addr_o <= {vec_page_r, refresh_r};
        ctrl_o.refresh_strobe_n <= 1'b0;
        ctrl_o.memory_request_n <= 1'b0;
      end
      else if (in_mid && state_r != ST_T1)
      begin
        addr_o <= is_io ? {8'h00, cyc_addr_r[7:0]} : cyc_addr_r;
        ctrl_o.opcode_fetch_cycle_n <= !is_fetch;
        if (is_ack_r)
          ctrl_o.port_request_n <= 1'b0;
        else if (is_io)
          ctrl_o.port_request_n <= 1'b0;
        else
          ctrl_o.memory_request_n <= 1'b0;
        ctrl_o.read_n <= is_wr || is_ack_r;
        ctrl_o.write_n <= !is_wr;
        data_oe <= is_wr;
      end
      else if (state_r == ST_T1)
      begin
        addr_o <= is_io ? {8'h00, cyc_addr_r[7:0]} : cyc_addr_r;
        data_oe <= is_wr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  chk_grant_float: assert property (@(posedge sys_clk) disable iff (!nrst)
    !bus_hold_grant_n |-> (!addr_oe && !data_oe && !ctrl_oe)) else $error("grant with bus driven");
  chk_refresh_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
    !ctrl_o.refresh_strobe_n |-> (addr_o[15:8] == $past(vec_page_r) && !ctrl_o.memory_request_n))
    else $error("refresh address wrong");
  chk_ack_no_io: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!ctrl_o.port_request_n && !ctrl_o.opcode_fetch_cycle_n) |-> ctrl_o.read_n && ctrl_o.write_n)
    else $error("io during fetch");
  chk_wait_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_r == ST_TW && wait_act) |=> state_r == ST_TW) else $error("wait dropped");
  chk_refresh_top: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_r == ST_T4 && !(reg_wr && reg_addr == CBI_REG_REFRESH)) |=>
    refresh_r[7] == $past(refresh_r[7]) && refresh_r[6:0] == $past(refresh_r[6:0]) + 7'h01)
    else $error("refresh count wrong");
  chk_wr_data: assert property (@(posedge sys_clk) disable iff (!nrst)
    !ctrl_o.write_n |-> data_oe) else $error("write without data");
  // An acknowledge carries the counter on the address bus, so only true port cycles are checked.
  chk_io_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!ctrl_o.port_request_n && ctrl_o.opcode_fetch_cycle_n) |-> addr_o[15:8] == 8'h00)
    else $error("port address high");
  chk_hold_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cyc_end && hold_act) |=> state_r == ST_HOLD ##1 !bus_hold_grant_n) else $error("hold late");
  chk_no_int_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cyc_end && hold_act && !ack_pend_r) |=> !ack_pend_r) else $error("int under hold");

  cov_hold: cover property (@(posedge sys_clk) disable iff (!nrst) !bus_hold_grant_n);
  cov_refresh: cover property (@(posedge sys_clk) disable iff (!nrst) !ctrl_o.refresh_strobe_n);
  cov_wait: cover property (@(posedge sys_clk) disable iff (!nrst) state_r == ST_TW ##1 state_r == ST_T3);
  cov_nmi: cover property (@(posedge sys_clk) disable iff (!nrst) busy_r);

endmodule

// ### testbench/cbi_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Memory and port partner with optional wait stretching.
// ------------------------------------------------------------
module cbi_mem_model
  import cbi_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic [15:0] addr_o, // Address bus from the core.
  input wire logic [7:0] data_o, // Write data from the core.
  input wire cbi_ctrl_t ctrl_o, // Control strobes from the core.
  input wire logic ctrl_oe, // Control strobe enable.
  input wire logic slow, // Request wait states when high.
  output logic [7:0] data_i, // Data returned to the core.
  output logic wait_n // Wait request to the core.
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;
  logic [3:0] cnt_r = 4'h0;
  logic drv;
  logic ack;
  // An acknowledge is a port request together with the fetch flag.
  assign ack = !ctrl_o.port_request_n && !ctrl_o.opcode_fetch_cycle_n;
  // Data only while read or acknowledge; refresh leaves the bus released.
  assign drv = ctrl_oe && (!ctrl_o.read_n || ack);
  assign data_i = !drv ? ~last_r : (ack ? 8'h40 : mem[addr_o[7:0]]);
  // A slow partner holds wait for eight strobe cycles.
  assign wait_n = !(slow && cnt_r < 4'h8);
  // Store writes and count strobe cycles.
  always_ff @(posedge sys_clk)
  begin
    last_r <= data_i;
    cnt_r <= (ctrl_o.read_n && ctrl_o.write_n) ? 4'h0 : cnt_r + {3'h0, cnt_r < 4'h8};
    if (ctrl_oe && !ctrl_o.write_n)
      mem[addr_o[7:0]] <= data_o;
  end
endmodule

// ### testbench/tb_cbi_core.sv
`timescale 1ns/1ps
module tb_cbi_core
  import cbi_pkg::*;
;
  logic sys_clk, nrst, reg_wr, reg_rd, wait_n, int_n, nmi_n, bus_hold_request_n, slow;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [15:0] addr_o, fe_a, rf_a, wr_a, io_a, rd_a;
  logic [7:0] data_i, data_o, wr_d;
  logic addr_oe, data_oe, ctrl_oe, halt_n, bus_hold_grant_n, io_m1;
  cbi_ctrl_t ctrl_o;
  int miscompares = 0;
  int n_checks = 0;
  int rdl = 0;
  int rfc = 0;
  int nack = 0;

  cbi_core i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_o(addr_o), .addr_oe(addr_oe),
    .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .ctrl_o(ctrl_o), .ctrl_oe(ctrl_oe),
    .halt_n(halt_n), .bus_hold_grant_n(bus_hold_grant_n), .wait_n(wait_n), .int_n(int_n),
    .nmi_n(nmi_n), .bus_hold_request_n(bus_hold_request_n));
  cbi_mem_model i_mem (.sys_clk(sys_clk), .addr_o(addr_o), .data_o(data_o), .ctrl_o(ctrl_o),
    .ctrl_oe(ctrl_oe), .slow(slow), .data_i(data_i), .wait_n(wait_n));

  // Clock at 100 MHz.
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Bus monitor records what each kind of cycle put on the pins.
  always @(posedge sys_clk)
  begin
    if (ctrl_oe && !ctrl_o.read_n) rd_a <= addr_o;
    if (ctrl_oe && !ctrl_o.read_n) rdl <= rdl + 1;
    if (!ctrl_o.opcode_fetch_cycle_n && !ctrl_o.read_n) fe_a <= addr_o;
    if (!ctrl_o.refresh_strobe_n) rf_a <= addr_o;
    if (!ctrl_o.refresh_strobe_n) rfc <= rfc + 1;
    if (!ctrl_o.write_n) wr_a <= addr_o;
    if (!ctrl_o.write_n) wr_d <= data_o;
    if (!ctrl_o.port_request_n) io_a <= addr_o;
    if (!ctrl_o.port_request_n) io_m1 <= ctrl_o.opcode_fetch_cycle_n;
    if (!ctrl_o.port_request_n && !ctrl_o.opcode_fetch_cycle_n) nack <= nack + 1;
  end

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Issue one bus command and let it run to its end.
  task automatic go(logic [3:0] k, logic [15:0] a, logic [7:0] d);
    wr(CBI_REG_CMD, {a, d, 4'h0, k});
    repeat (40) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset;
    nrst <= 1'b1;
    #1;
    chk("oe", {addr_oe, data_oe, ctrl_oe}, 3'h0);
    chk("ctrl", ctrl_o, CBI_CTRL_IDLE);
    chk("grant_halt", {bus_hold_grant_n, halt_n}, 2'h3);
    rd(CBI_REG_VEC_PAGE);
    chk("page", v, CBI_VEC_PAGE_RESET);
    rd(CBI_REG_REFRESH);
    chk("refresh", v, CBI_REFRESH_RESET);
    rd(CBI_REG_CTRL);
    chk("ctrl_reg", v, 32'h0000_0000);
    rd(CBI_REG_PC);
    chk("pc", v[15:0], CBI_PC_RESET);
    rd(4'hF);
    chk("unmapped", v, 32'h0000_0000);
  endtask

  task automatic t_fetch;
    wr(CBI_REG_VEC_PAGE, 32'h0000_005A);
    wr(CBI_REG_REFRESH, 32'h0000_00FF);
    go(CBI_CMD_FETCH, 16'h1234, 8'h00);
    chk("fetch", fe_a, 16'h1234);
    chk("refresh_strobe_n_page", rf_a, 16'h5AFF);
    rd(CBI_REG_REFRESH);
    chk("refresh_strobe_n_cnt", v, 32'h0000_0080);
    go(CBI_CMD_FETCH2, 16'h1235, 8'h00);
    chk("fetch2", fe_a, 16'h1235);
    rd(CBI_REG_REFRESH);
    chk("refresh_strobe_n_cnt2", v, 32'h0000_0081);
  endtask

  task automatic t_index;
    wr(CBI_REG_INDEX1, 32'h0000_1000);
    go(CBI_CMD_IDX_RD, 16'h0000, 8'hF0);
    chk("idx1", rd_a, 16'h0FF0);
    wr(CBI_REG_INDEX2, 32'h0000_2000);
    wr(CBI_REG_CTRL, 32'h0000_0008);
    go(CBI_CMD_IDX_RD, 16'h0000, 8'h10);
    chk("idx2", rd_a, 16'h2010);
    wr(CBI_REG_CTRL, 32'h0000_0000);
  endtask

  task automatic t_mem;
    int n;
    go(CBI_CMD_MEM_WR, 16'hABCD, 8'h3C);
    chk("wr_addr", wr_a, 16'hABCD);
    chk("wr_data", wr_d, 8'h3C);
    n = rdl;
    slow <= 1'b1;
    go(CBI_CMD_MEM_RD, 16'h00CD, 8'h00);
    slow <= 1'b0;
    chk("rd_addr", rd_a, 16'h00CD);
    chk("stretch", rdl - n >= 8, 1'b1);
    rd(CBI_REG_DATA);
    chk("rd_data", v, 32'h0000_003C);
  endtask

  task automatic t_io;
    go(CBI_CMD_IO_WR, 16'hBE77, 8'h11);
    chk("io_addr", io_a[7:0], 8'h77);
    chk("io_fetch", io_m1, 1'b1);
    go(CBI_CMD_IO_RD, 16'h0077, 8'h00);
    rd(CBI_REG_DATA);
    chk("io_data", v, 32'h0000_0011);
  endtask

  task automatic t_hold;
    slow <= 1'b1;
    wr(CBI_REG_CMD, {16'h00CD, 12'h000, CBI_CMD_MEM_RD});
    bus_hold_request_n <= 1'b0;
    repeat (30) if (bus_hold_grant_n !== 1'b0) @(posedge sys_clk);
    #1;
    slow <= 1'b0;
    chk("hold_end", rd_a, 16'h00CD);
    chk("grant", bus_hold_grant_n, 1'b0);
    chk("float", {addr_oe, data_oe, ctrl_oe}, 3'h0);
    go(CBI_CMD_FETCH, 16'h0444, 8'h00);
    chk("held", fe_a, 16'h1235);
    bus_hold_request_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic t_int;
    int n;
    n = nack;
    int_n <= 1'b0;
    go(CBI_CMD_FETCH, 16'h0300, 8'h00);
    chk("ack_off", nack - n, 32'h0000_0000);
    wr(CBI_REG_CTRL, 32'h0000_0005);
    go(CBI_CMD_FETCH, 16'h0301, 8'h00);
    chk("ack_on", nack - n, 32'h0000_0001);
    int_n <= 1'b1;
    rd(CBI_REG_CTRL);
    chk("ien_clr", v[2:0], 3'h4);
    rd(CBI_REG_DATA);
    chk("vec_lo", v, 32'h0000_0040);
  endtask

  task automatic t_halt;
    int n;
    logic [15:0] p;
    go(CBI_CMD_HALT, 16'h0500, 8'h00);
    chk("halt", halt_n, 1'b0);
    n = rfc;
    repeat (30) @(posedge sys_clk);
    #1;
    chk("idle_refresh_strobe_n", rfc > n, 1'b1);
    rd(CBI_REG_PC);
    p = v[15:0];
    nmi_n <= 1'b0;
    repeat (60) @(posedge sys_clk);
    #1;
    nmi_n <= 1'b1;
    chk("nmi_fetch", fe_a, CBI_NMI_VECTOR);
    chk("halt_exit", halt_n, 1'b1);
    chk("push_hi", i_mem.mem[8'hFE], p[15:8]);
    chk("push_lo", i_mem.mem[8'hFD], p[7:0]);
  endtask

  task automatic t_alu;
    cbi_alu_op_t ops [5] = '{CBI_ALU_ADD, CBI_ALU_SUB, CBI_ALU_AND, CBI_ALU_OR, CBI_ALU_XOR};
    logic [7:0] ex [5] = '{8'h1D, 8'h69, 8'h42, 8'hDB, 8'h99};
    for (int i = 0; i < 5; i++)
    begin
      wr(CBI_REG_ALU, {12'h000, ops[i], 8'h5A, 8'hC3});
      rd(CBI_REG_ALU);
      chk("alu", v[7:0], ex[i]);
    end
  endtask

  task automatic conclude;
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog cuts a hang short.
  initial
  begin
    #200_000;
    miscompares++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    {nrst, reg_wr, reg_rd, slow} = 4'h0;
    {int_n, nmi_n, bus_hold_request_n} = 3'h7;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    repeat (20) @(posedge sys_clk);
    t_reset();
    t_fetch();
    t_index();
    t_mem();
    t_io();
    t_hold();
    t_int();
    t_halt();
    t_alu();
    conclude();
  end
endmodule
